// >>> logic/pdw_power_down_wakeup.v
// Power-down sequencing and wakeup detection with wakeup and pull-up registers.
`timescale 1ns/10ps
`include "pdw_map.vh"

module pdw_power_down_wakeup
#(
	parameter KEY_W = 24
)
(
	// Clock and reset.
	input  wire             sys_clk,
	input  wire             reset,
	// Instruction strobes from the core, one cycle each.
	input  wire             sleepArmInstr,
	input  wire             sleepClockedInstr,
	input  wire             sleepBackupInstr,
	input  wire             dropDetectSleepEnableInstr,
	input  wire             anyInstr,
	// Accumulator transfer port.
	input  wire             accWrite,
	input  wire             accRead,
	input  wire [2:0]       regSel,
	input  wire [3:0]       accIn,
	output reg  [3:0]       accOut_ff,
	// State from the rest of the chip.
	input  wire             clockCountUnderflow,
	input  wire             clockCountReqFlag,
	input  wire             intPolarityHigh,
	input  wire [1:0]       timerOneCntrSel,
	input  wire             dropDetectPin,
	// Pins: P0..P3 on bits 15..0, D0..D7 on bits 23..16; interrupt pin.
	input  wire [KEY_W-1:0] keyPins,
	input  wire             intPin,
	// Sequencer outputs.
	output reg              cpuInitPulse_ff,
	output reg              warmRestart_ff,
	output reg              powerDownFlag_ff,
	output reg  [2:0]       stackPointerInit_ff,
	output reg              extReqSet_ff,
	output reg              sleeping_ff,
	output reg              oscStop_ff,
	output reg              displayOn_ff,
	output reg              dropDetectActive_ff,
	output reg              carrierPinOut_ff,
	output reg              carrierPinOe_ff,
	output reg  [15:0]      pullupEnable_ff
);

	// ************************************************************
	// Registers
	// ************************************************************
	reg [3:0] keyWakeEnableA_ff;
	reg [3:0] keyWakeEnableB_ff;
	reg [3:0] keyWakeEnableC_ff;
	reg [3:0] keyWakeEnableD_ff;
	reg [3:0] pullupEnableA_ff;
	reg [3:0] pullupEnableB_ff;
	reg [3:0] pullupEnableC_ff;
	reg [3:0] pullupEnableD_ff;
	reg [1:0] mode_ff;
	reg       armed_ff;
	reg       dropSleepArm_ff;
	reg [KEY_W-1:0] keyMeta_ff;
	reg [KEY_W-1:0] keySync_ff;
	reg [KEY_W-1:0] keyPrev_ff;
	reg       intMeta_ff;
	reg       intSync_ff;
	reg       intPrev_ff;
	reg       cntMeta_ff;
	reg       cntSync_ff;
	reg       uflMeta_ff;
	reg       uflSync_ff;
	reg       dropMeta_ff;
	reg       dropSync_ff;

	wire [KEY_W-1:0] keyEnable;
	// Per-group enables, widened to one bit per pin before they are joined.
	wire [7:0]       keyEnPortLow;
	wire [3:0]       keyEnPortTwo;
	wire [3:0]       keyEnPortThree;
	wire [7:0]       keyEnPortD;
	// Pull-up pin enables as they will stand in the output flop.
	wire [15:0]      nxtPullupEnable;
	wire [KEY_W-1:0] keyFall;
	wire       intLevelHit;
	wire       intEdgeHit;
	wire       intWake;
	wire       extWake;
	wire       timerWake;
	wire       wakeNow;
	wire       enterClocked;
	wire       enterBackup;

	// Expands four pair-enable bits to eight pin enables.
	function [7:0] pairs;
		input [3:0] e;
		begin
			pairs = {{2{e[3]}}, {2{e[2]}}, {2{e[1]}}, {2{e[0]}}};
		end
	endfunction

	// ************************************************************
	// Register writes and reads
	// ************************************************************
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			keyWakeEnableA_ff <= `PDW_REG_RESET;
			keyWakeEnableB_ff <= `PDW_REG_RESET;
			keyWakeEnableC_ff <= `PDW_REG_RESET;
			keyWakeEnableD_ff <= `PDW_REG_RESET;
			pullupEnableA_ff  <= `PDW_REG_RESET;
			pullupEnableB_ff  <= `PDW_REG_RESET;
			pullupEnableC_ff  <= `PDW_REG_RESET;
			pullupEnableD_ff  <= `PDW_REG_RESET;
			accOut_ff         <= 4'h0;
		end
		else
		begin
			// Retained across sleep: nothing below depends on the mode.
			if (accWrite)
			begin
				case (regSel)
					`PDW_SEL_WAKE_A: keyWakeEnableA_ff <= accIn;
					`PDW_SEL_WAKE_B: keyWakeEnableB_ff <= accIn;
					`PDW_SEL_WAKE_C: keyWakeEnableC_ff <= accIn;
					`PDW_SEL_WAKE_D: keyWakeEnableD_ff <= accIn;
					`PDW_SEL_PULL_A: pullupEnableA_ff <= accIn;
					`PDW_SEL_PULL_B: pullupEnableB_ff <= accIn;
					`PDW_SEL_PULL_C: pullupEnableC_ff <= accIn;
					`PDW_SEL_PULL_D: pullupEnableD_ff <= accIn;
					default: ;
				endcase
			end
			if (accRead)
			begin
				case (regSel)
					`PDW_SEL_WAKE_A: accOut_ff <= keyWakeEnableA_ff;
					`PDW_SEL_WAKE_B: accOut_ff <= keyWakeEnableB_ff;
					`PDW_SEL_WAKE_C: accOut_ff <= keyWakeEnableC_ff;
					`PDW_SEL_WAKE_D: accOut_ff <= keyWakeEnableD_ff;
					`PDW_SEL_PULL_A: accOut_ff <= pullupEnableA_ff;
					`PDW_SEL_PULL_B: accOut_ff <= pullupEnableB_ff;
					`PDW_SEL_PULL_C: accOut_ff <= pullupEnableC_ff;
					default:         accOut_ff <= pullupEnableD_ff;
				endcase
			end
		end
	end

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	// Asynchronous pins pass two flops before use; a pulse sampled at a single clock edge still gets through.
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			keyMeta_ff  <= {KEY_W{1'b1}};
			keySync_ff  <= {KEY_W{1'b1}};
			keyPrev_ff  <= {KEY_W{1'b1}};
			intMeta_ff  <= 1'b0;
			intSync_ff  <= 1'b0;
			intPrev_ff  <= 1'b0;
			cntMeta_ff  <= 1'b0;
			cntSync_ff  <= 1'b0;
			uflMeta_ff  <= 1'b0;
			uflSync_ff  <= 1'b0;
			dropMeta_ff <= 1'b0;
			dropSync_ff <= 1'b0;
		end
		else
		begin
			keyMeta_ff  <= keyPins;
			keySync_ff  <= keyMeta_ff;
			keyPrev_ff  <= keySync_ff;
			intMeta_ff  <= intPin;
			intSync_ff  <= intMeta_ff;
			intPrev_ff  <= intSync_ff;
			cntMeta_ff  <= clockCountReqFlag;
			cntSync_ff  <= cntMeta_ff;
			uflMeta_ff  <= clockCountUnderflow;
			uflSync_ff  <= uflMeta_ff;
			dropMeta_ff <= dropDetectPin;
			dropSync_ff <= dropMeta_ff;
		end
	end

	// ************************************************************
	// Wakeup detection
	// ************************************************************
	// ************************************************************
	// Key enable map
	// ************************************************************
	// The pin vector is laid out with P0/P1 lowest, then P2, then P3,
	// and the D port on top. Each group is brought to exactly its own
	// width here so that the join below is the full vector and no bit of
	// one group can slide into the next.
	//
	// Ports P0 and P1 are enabled two pins per bit.
	assign keyEnPortLow   = pairs(keyWakeEnableA_ff);
	// Port P2 is enabled one pin per bit.
	assign keyEnPortTwo   = keyWakeEnableB_ff;
	// Port P3 shares its register with the interrupt pin controls, so
	// only the upper two bits are pair enables; the lower two never
	// reach a key line.
	assign keyEnPortThree = {{2{keyWakeEnableC_ff[3]}}, {2{keyWakeEnableC_ff[2]}}};
	// The D port is enabled two pins per bit.
	assign keyEnPortD     = pairs(keyWakeEnableD_ff);
	assign keyEnable      = {keyEnPortD, keyEnPortThree, keyEnPortTwo, keyEnPortLow};

	// A key wakes only on a high-to-low change of its synchronised level.
	// A key that is already held low when the core goes to sleep does not
	// wake it; the user must release and press again.
	assign keyFall = keyPrev_ff & ~keySync_ff & keyEnable;

	// ************************************************************
	// Pull-up map
	// ************************************************************
	// P0/P1 pull-ups are switched in pairs, P2 and P3 pin by pin. The
	// D-port pull-up register is kept and read back but has no pin here.
	assign nxtPullupEnable = {pullupEnableC_ff, pullupEnableB_ff, pairs(pullupEnableA_ff)};

	// Polarity follows the external interrupt control bit.
	assign intLevelHit = (intSync_ff == intPolarityHigh);
	assign intEdgeHit  = intPolarityHigh ? (intSync_ff & ~intPrev_ff) : (~intSync_ff & intPrev_ff);
	assign intWake = keyWakeEnableC_ff[`PDW_C_IRQ_EN_BIT] &
		(keyWakeEnableC_ff[`PDW_C_EDGE_BIT] ? intEdgeHit : intLevelHit);
	assign extWake   = (|keyFall) | intWake;
	assign timerWake = uflSync_ff | cntSync_ff;
	assign wakeNow   = extWake | ((mode_ff == `PDW_MODE_CLOCKED) & timerWake);

	// Sleep instructions are ignored unless the arm instruction came just before.
	assign enterClocked = armed_ff & sleepClockedInstr;
	assign enterBackup  = armed_ff & sleepBackupInstr & ~sleepClockedInstr;

	// ************************************************************
	// Sleep sequencer
	// ************************************************************
	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			mode_ff             <= `PDW_MODE_RUN;
			armed_ff            <= 1'b0;
			dropSleepArm_ff     <= 1'b0;
			cpuInitPulse_ff     <= 1'b0;
			warmRestart_ff      <= 1'b0;
			powerDownFlag_ff    <= 1'b0;
			stackPointerInit_ff <= `PDW_SP_SLEEP;
			extReqSet_ff        <= 1'b0;
			sleeping_ff         <= 1'b0;
			oscStop_ff          <= 1'b0;
			displayOn_ff        <= 1'b1;
			dropDetectActive_ff <= 1'b0;
			carrierPinOut_ff    <= 1'b0;
			carrierPinOe_ff     <= 1'b0;
			pullupEnable_ff     <= 16'h0000;
		end
		else
		begin
			cpuInitPulse_ff <= 1'b0;
			warmRestart_ff  <= 1'b0;
			extReqSet_ff    <= 1'b0;
			// Pull-ups are retained through sleep, so they follow the
			// registers in every mode.
			pullupEnable_ff <= nxtPullupEnable;
			if (anyInstr)
				armed_ff <= sleepArmInstr;
			if (dropDetectSleepEnableInstr)
				dropSleepArm_ff <= 1'b1;
			case (mode_ff)
				`PDW_MODE_RUN:
				begin
					sleeping_ff         <= 1'b0;
					oscStop_ff          <= 1'b0;
					displayOn_ff        <= 1'b1;
					dropDetectActive_ff <= dropSync_ff;
					carrierPinOe_ff     <= 1'b0;
					if (enterClocked | enterBackup)
					begin
						mode_ff  <= enterClocked ? `PDW_MODE_CLOCKED : `PDW_MODE_BACKUP;
						armed_ff <= 1'b0;
						// Core, interrupt enables, PA/timer-two control, watchdog reinit.
						cpuInitPulse_ff     <= 1'b1;
						stackPointerInit_ff <= `PDW_SP_SLEEP;
						// External request, global enable and drop flag cleared by this pulse.
						// Timers one and two are left free; core treats them as undefined.
						sleeping_ff  <= 1'b1;
						oscStop_ff   <= enterBackup;
						displayOn_ff <= enterClocked;
						dropDetectActive_ff <= dropSleepArm_ff & dropSync_ff;
						carrierPinOut_ff <= 1'b0;
						carrierPinOe_ff  <= (timerOneCntrSel != `PDW_CNTR_SEL);
					end
				end
				`PDW_MODE_CLOCKED, `PDW_MODE_BACKUP:
				begin
					dropDetectActive_ff <= dropSleepArm_ff & dropSync_ff;
					if (wakeNow)
					begin
						mode_ff          <= `PDW_MODE_RUN;
						warmRestart_ff   <= 1'b1;
						powerDownFlag_ff <= 1'b1;
						// A level return leaves the external request flag clear.
						extReqSet_ff     <= intWake & keyWakeEnableC_ff[`PDW_C_EDGE_BIT];
						sleeping_ff      <= 1'b0;
						oscStop_ff       <= 1'b0;
						displayOn_ff     <= 1'b1;
						carrierPinOe_ff  <= 1'b0;
					end
				end
				default:
					mode_ff <= `PDW_MODE_RUN;
			endcase
		end
	end

endmodule // pdw_power_down_wakeup

// >>> logic/pdw_map.vh
// Constants for the power-down and wakeup control block.
`ifndef PDW_MAP_VH
`define PDW_MAP_VH
// Register select codes used with the accumulator transfer strobes.
`define PDW_SEL_WAKE_A     3'h0
`define PDW_SEL_WAKE_B     3'h1
`define PDW_SEL_WAKE_C     3'h2
`define PDW_SEL_WAKE_D     3'h3
`define PDW_SEL_PULL_A     3'h4
`define PDW_SEL_PULL_B     3'h5
`define PDW_SEL_PULL_C     3'h6
`define PDW_SEL_PULL_D     3'h7
// Reset values.
`define PDW_REG_RESET      4'h0
// Field positions in the third wakeup register.
`define PDW_C_IRQ_EN_BIT   0
`define PDW_C_EDGE_BIT     1
// Stack level forced in power-down.
`define PDW_SP_SLEEP       3'h7
// Counter-input selection in the timer-one control bits.
`define PDW_CNTR_SEL       2'h3
// Sleep mode codes.
`define PDW_MODE_RUN       2'h0
`define PDW_MODE_CLOCKED   2'h1
`define PDW_MODE_BACKUP    2'h2
`endif

// >>> sim/pdw_props.sv
// Port checks for the power-down and wakeup block.
`timescale 1ns/10ps
module pdw_props
(
	// Clock and reset.
	input wire       sys_clk,
	input wire       reset,
	// Instruction strobes.
	input wire       sleepArmInstr,
	input wire       sleepClockedInstr,
	input wire       sleepBackupInstr,
	input wire       anyInstr,
	input wire [1:0] timerOneCntrSel,
	// Sequencer outputs.
	input wire       cpuInitPulse_ff,
	input wire       warmRestart_ff,
	input wire       powerDownFlag_ff,
	input wire [2:0] stackPointerInit_ff,
	input wire       extReqSet_ff,
	input wire       sleeping_ff,
	input wire       oscStop_ff,
	input wire       displayOn_ff,
	input wire       carrierPinOut_ff,
	input wire       carrierPinOe_ff
);
	// ****************
	// Assertions
	// ****************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire sleepReq = sleepClockedInstr | sleepBackupInstr;
	a_sp_level_seven: assert property (stackPointerInit_ff == 3'h7) else $error("stack level wrong");
	a_init_on_entry: assert property ($rose(sleeping_ff) |-> cpuInitPulse_ff) else $error("no reinit");
	a_unarmed_sleep_ignored: assert property (sleepReq && !sleeping_ff && $past(anyInstr) && !$past(sleepArmInstr)
		|=> !cpuInitPulse_ff) else $error("unarmed sleep taken");
	a_backup_display_off: assert property (sleeping_ff && oscStop_ff |-> !displayOn_ff) else $error("display on");
	a_clocked_display_on: assert property (sleeping_ff && !oscStop_ff |-> displayOn_ff) else $error("display off");
	a_carrier_pin_low: assert property (sleeping_ff && $past(sleeping_ff) && timerOneCntrSel != 2'h3
		&& $past(timerOneCntrSel) != 2'h3 |-> carrierPinOe_ff && !carrierPinOut_ff) else $error("carrier pin");
	a_warm_sets_flag: assert property (warmRestart_ff |=> powerDownFlag_ff) else $error("flag not set");
	a_wake_ends_sleep: assert property ($fell(sleeping_ff) && !$past(reset) |-> ##[0:1] warmRestart_ff)
		else $error("no restart pulse");
	c_warm: cover property (warmRestart_ff);
	c_edge: cover property (extReqSet_ff);
	c_backup: cover property (sleeping_ff && oscStop_ff);
endmodule // pdw_props

// >>> sim/pdw_key_model.sv
// Key switches and interrupt pin driver.
`timescale 1ns/10ps
module pdw_key_model
(
	// Pins.
	output logic [23:0] keyPins,
	output logic        intPin
);
	// ****************
	// Pins idle high on their pull-ups
	// ****************
	initial
	begin
		keyPins = 24'hffffff;
		intPin = 1'b1;
	end
	// A pressed key pulls its line low.
	task press(input logic [23:0] m);
		keyPins = ~m;
	endtask
	task setInt(input logic v);
		intPin = v;
	endtask
endmodule // pdw_key_model

// >>> sim/tb_top.sv
// Self-checking bench for the power-down and wakeup block.
`timescale 1ns/10ps
module tb_top;
	// ****************
	// Signals and instances
	// ****************
	logic sys_clk = 1'b0, reset = 1'b1, sleepArmInstr = 1'b0, sleepClockedInstr = 1'b0, sleepBackupInstr = 1'b0;
	logic anyInstr = 1'b0, accWrite = 1'b0, accRead = 1'b0, clockCountUnderflow = 1'b0, clockCountReqFlag = 1'b0;
	logic intPolarityHigh = 1'b0, cpuInitPulse_ff, warmRestart_ff, powerDownFlag_ff, extReqSet_ff, sleeping_ff;
	logic oscStop_ff, displayOn_ff, dropDetectActive_ff, carrierPinOut_ff, carrierPinOe_ff, intPin, ext;
	logic dropDetectSleepEnableInstr = 1'b0, dropDetectPin = 1'b0;
	logic [1:0]  timerOneCntrSel = 2'h0;
	logic [2:0]  regSel = 3'h0, stackPointerInit_ff;
	logic [3:0]  accIn = 4'h0, accOut_ff;
	logic [15:0] pullupEnable_ff;
	logic [23:0] keyPins;
	int          errorCnt = 0, comparisons = 0, cycles = 0;
	pdw_key_model pdw_key_model_i (.keyPins(keyPins), .intPin(intPin));
	pdw_power_down_wakeup pdw_power_down_wakeup_i (.sys_clk(sys_clk), .reset(reset), .sleepArmInstr(sleepArmInstr),
		.sleepClockedInstr(sleepClockedInstr), .sleepBackupInstr(sleepBackupInstr),
		.dropDetectSleepEnableInstr(dropDetectSleepEnableInstr),
		.anyInstr(anyInstr), .accWrite(accWrite), .accRead(accRead), .regSel(regSel), .accIn(accIn),
		.accOut_ff(accOut_ff), .clockCountUnderflow(clockCountUnderflow), .clockCountReqFlag(clockCountReqFlag),
		.intPolarityHigh(intPolarityHigh), .timerOneCntrSel(timerOneCntrSel), .dropDetectPin(dropDetectPin),
		.keyPins(keyPins),
		.intPin(intPin), .cpuInitPulse_ff(cpuInitPulse_ff), .warmRestart_ff(warmRestart_ff),
		.powerDownFlag_ff(powerDownFlag_ff), .stackPointerInit_ff(stackPointerInit_ff), .extReqSet_ff(extReqSet_ff),
		.sleeping_ff(sleeping_ff), .oscStop_ff(oscStop_ff), .displayOn_ff(displayOn_ff),
		.dropDetectActive_ff(dropDetectActive_ff), .carrierPinOut_ff(carrierPinOut_ff),
		.carrierPinOe_ff(carrierPinOe_ff), .pullupEnable_ff(pullupEnable_ff));
	initial
	begin
		forever #10 sys_clk = ~sys_clk;
	end
	// A hung wait never reaches the verdict otherwise.
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errorCnt++;
			final_report();
		end
	end
	// ****************
	// Shared tasks
	// ****************
	task cyc();
		@(posedge sys_clk);
		#2;
	endtask
	task chk(input logic [15:0] g, e);
		comparisons++;
		if (g !== e)
		begin
			errorCnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task instr(input int k);
		{sleepArmInstr, sleepClockedInstr, sleepBackupInstr, anyInstr} = {k == 0, k == 1, k == 2, 1'b1};
		cyc();
		{sleepArmInstr, sleepClockedInstr, sleepBackupInstr, anyInstr} = 4'h0;
	endtask
	task wr(input logic [2:0] s, input logic [3:0] v);
		{accWrite, regSel, accIn} = {1'b1, s, v};
		cyc();
		accWrite = 1'b0;
	endtask
	task rd(input logic [2:0] s, input logic [3:0] e);
		{accRead, regSel} = {1'b1, s};
		cyc();
		accRead = 1'b0;
		chk(accOut_ff, e);
	endtask
	task sleep(input int k);
		instr(0);
		cyc();
		instr(k);
		chk(cpuInitPulse_ff, 1'b1);
	endtask
	task waitWake();
		ext = 1'b0;
		repeat (20)
		begin
			if (warmRestart_ff !== 1'b1)
			begin
				cyc();
				ext |= extReqSet_ff;
			end
		end
		chk(warmRestart_ff, 1'b1);
		cyc();
		chk({powerDownFlag_ff, sleeping_ff}, 2'h2);
	endtask
	// ****************
	// Scenarios
	// ****************
	task t_reset();
		for (int i = 0; i < 8; i++)
			rd(i, 4'h0);
		chk({stackPointerInit_ff, displayOn_ff, powerDownFlag_ff}, 5'h1e);
		$display("reset test done");
	endtask
	task t_regs();
		for (int i = 0; i < 8; i++)
			wr(i, 4'h5 + i);
		for (int i = 0; i < 8; i++)
			rd(i, 4'h5 + i);
		chk(pullupEnable_ff, 16'hbac3);
		$display("register test done");
	endtask
	task t_noarm();
		// An arm followed by another instruction no longer arms the sleep.
		{sleepArmInstr, anyInstr} = 2'h3;
		cyc();
		sleepArmInstr = 1'b0;
		cyc();
		sleepClockedInstr = 1'b1;
		cyc();
		{sleepClockedInstr, anyInstr} = 2'h0;
		repeat (3) cyc();
		chk(sleeping_ff, 1'b0);
		$display("unarmed sleep test done");
	endtask
	task t_key();
		dropDetectPin = 1'b1;
		wr(0, 4'h1);
		wr(2, 4'h0);
		sleep(1);
		chk({sleeping_ff, displayOn_ff, carrierPinOe_ff, carrierPinOut_ff}, 4'he);
		chk(dropDetectActive_ff, 1'b0);
		pdw_key_model_i.press(24'h000003);
		waitWake();
		pdw_key_model_i.press(24'h0);
		$display("key wake test done");
	endtask
	task t_backup_int();
		wr(0, 4'h0);
		wr(2, 4'h3);
		timerOneCntrSel = 2'h3;
		sleep(2);
		clockCountUnderflow = 1'b1;
		repeat (8) cyc();
		chk({sleeping_ff, oscStop_ff, displayOn_ff, carrierPinOe_ff}, 4'hc);
		clockCountUnderflow = 1'b0;
		pdw_key_model_i.setInt(1'b0);
		waitWake();
		chk(ext, 1'b1);
		timerOneCntrSel = 2'h0;
		pdw_key_model_i.setInt(1'b1);
		$display("interrupt pin wake test done");
	endtask
	task t_flag();
		dropDetectSleepEnableInstr = 1'b1;
		cyc();
		dropDetectSleepEnableInstr = 1'b0;
		clockCountReqFlag = 1'b1;
		sleep(1);
		chk(dropDetectActive_ff, 1'b1);
		waitWake();
		chk(ext, 1'b0);
		clockCountReqFlag = 1'b0;
		$display("pending flag wake test done");
	endtask
	task final_report();
		$display("comparisons=%0d mismatches=%0d", comparisons, errorCnt);
		if (errorCnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (12) cyc();
		reset = 1'b0;
		t_reset();
		t_regs();
		t_noarm();
		t_key();
		t_backup_int();
		t_flag();
		final_report();
	end
endmodule // tb_top
bind pdw_power_down_wakeup pdw_props pdw_props_i (.sys_clk(sys_clk), .reset(reset), .sleepArmInstr(sleepArmInstr),
	.sleepClockedInstr(sleepClockedInstr), .sleepBackupInstr(sleepBackupInstr), .anyInstr(anyInstr),
	.timerOneCntrSel(timerOneCntrSel), .cpuInitPulse_ff(cpuInitPulse_ff), .warmRestart_ff(warmRestart_ff),
	.powerDownFlag_ff(powerDownFlag_ff), .stackPointerInit_ff(stackPointerInit_ff), .extReqSet_ff(extReqSet_ff),
	.sleeping_ff(sleeping_ff), .oscStop_ff(oscStop_ff), .displayOn_ff(displayOn_ff),
	.carrierPinOut_ff(carrierPinOut_ff), .carrierPinOe_ff(carrierPinOe_ff));
